// file: hdl/disc_bus_master.sv
// Functional notes
// - Interrupt level from link setting, default five
// - Processor grants nearest requester on level
// - Request only when enabled and pending
// - Processor acknowledges only with no higher
// - Vector driven on vector lines after acknowledge
// - Arbitration may overlap ongoing data transfer
// - Four sixteen-bit words per acquisition default
// - Four microsecond idle gap between acquisitions
// - Burst length and gap are programmable
// - Non-processor request, then grant gives mastership
// - Host supplies block, count, address, direction
// - Release bus after complete or abort
// - Drive full eighteen-bit memory addresses
// - Master sync / slave sync handshake
// - Report parity and timeout errors
`timescale 1ns/1ps
`default_nettype none
`include "hbm_consts.svh"
module disc_bus_master
   import hbm_pkg::*;
#(
   parameter int GAP_CYC   = `IDLE_GAP_CYC,
   parameter int TMO_CYC   = `SYNC_TIMEOUT_CYC,
   parameter logic [2:0] LEVEL = 3'(`IRQ_LEVEL_DEFAULT)
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  levelLink,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq,
   host_bus_if.ctrl         hb
);
   typedef struct packed {
      logic        awr;
      logic        wr;
      logic [31:0] awa;
      logic [31:0] wd;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
      logic        write;
      logic        ie;
      logic [2:0]  lvl;
      logic        start;
      logic [31:0] gap;
      logic [7:0]  burst;
      logic [17:0] addr;
      logic [15:0] count;
      logic [31:0] block;
      logic [15:0] vector;
      logic [15:0] data;
      logic [6:0]  status;
      logic [6:0]  mask;
      logic        irq;
      dma_state_t  ds;
      irq_state_t  is;
      logic [7:0]  wcnt;
      logic [31:0] tmr;
      logic [4:0]  busReq;
      logic        npReq;
      logic        selAck;
      logic        busBusy;
      logic        mSync;
      logic        dirOut;
      logic [15:0] dataM;
      logic [15:0] vecOut;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   always_comb begin
      logic [7:0] wa;
      logic [7:0] ra;
      logic       pend;
      wa = 8'h00;
      ra = 8'h00;
      pend = 1'b0;
      st_nxt = st_r;
      st_nxt.start = 1'b0;
      // AXI write: take address and data in either order
      if (s_axi_awvalid && st_r.awr) begin
         st_nxt.awr = 1'b0;
         st_nxt.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wr) begin
         st_nxt.wr = 1'b0;
         st_nxt.wd = s_axi_wdata;
      end
      if (!st_r.awr && !st_r.wr && !st_r.bvalid) begin
         wa = st_r.awa[7:0];
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `BUS_OKAY;
         case (wa)
            `REG_CTRL: begin
               st_nxt.start = st_r.wd[`CTRL_START];
               st_nxt.write = st_r.wd[`CTRL_WRITE];
               st_nxt.ie = st_r.wd[`CTRL_IE];
            end
            `REG_GAP:    st_nxt.gap = st_r.wd;
            `REG_BURST:  st_nxt.burst = st_r.wd[7:0];
            `REG_ADDR:   st_nxt.addr = st_r.wd[17:0];
            `REG_COUNT:  st_nxt.count = st_r.wd[15:0];
            `REG_BLOCK:  st_nxt.block = st_r.wd;
            `REG_VECTOR: st_nxt.vector = st_r.wd[15:0];
            `REG_MASK:   st_nxt.mask = st_r.wd[6:0];
            `REG_DATA:   st_nxt.data = st_r.wd[15:0];
            `REG_STATUS: st_nxt.bresp = `BUS_OKAY;
            default:     st_nxt.bresp = `BUS_SLVERR;
         endcase
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
         st_nxt.awr = 1'b1;
         st_nxt.wr = 1'b1;
      end
      // AXI read; status cleared by read
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
         st_nxt.arready = 1'b1;
      end
      if (s_axi_arvalid && st_r.arready) begin
         ra = s_axi_araddr[7:0];
         st_nxt.arready = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `BUS_OKAY;
         st_nxt.rdata = 32'h0;
         case (ra)
            `REG_CTRL:   st_nxt.rdata = {25'h0, st_r.lvl, 1'b0, st_r.ie, st_r.write, 1'b0};
            `REG_GAP:    st_nxt.rdata = st_r.gap;
            `REG_BURST:  st_nxt.rdata = {24'h0, st_r.burst};
            `REG_ADDR:   st_nxt.rdata = {14'h0, st_r.addr};
            `REG_COUNT:  st_nxt.rdata = {16'h0, st_r.count};
            `REG_BLOCK:  st_nxt.rdata = st_r.block;
            `REG_VECTOR: st_nxt.rdata = {16'h0, st_r.vector};
            `REG_MASK:   st_nxt.rdata = {25'h0, st_r.mask};
            `REG_DATA:   st_nxt.rdata = {16'h0, st_r.data};
            `REG_STATUS: begin
               st_nxt.rdata = {25'h0, st_r.status};
               st_nxt.status = st_r.status & 7'h10;
            end
            default:     st_nxt.rresp = `BUS_SLVERR;
         endcase
      end
      st_nxt.status[`ST_BUSY] = (st_r.ds != DS_IDLE);
      st_nxt.lvl = levelLink;
      // DMA sequencer
      case (st_r.ds)
         DS_IDLE: begin
            if (st_r.start && st_r.count != 16'h0) begin
               st_nxt.npReq = 1'b1;
               st_nxt.ds = DS_REQ;
            end
         end
         DS_REQ: begin
            // Wait for previous master to drop busy
            if (hb.npGrant && !st_r.busBusy) begin
               st_nxt.selAck = 1'b1;
               st_nxt.npReq = 1'b0;
               st_nxt.busBusy = 1'b1;
               st_nxt.wcnt = st_r.burst;
               st_nxt.ds = DS_XFER;
            end
         end
         DS_XFER: begin
            st_nxt.selAck = 1'b0;
            st_nxt.mSync = 1'b1;
            st_nxt.dirOut = st_r.write;
            st_nxt.dataM = st_r.data;
            st_nxt.tmr = 32'h0;
            st_nxt.ds = DS_WAIT;
         end
         DS_WAIT: begin
            st_nxt.tmr = st_r.tmr + 32'h1;
            if (hb.sSync) begin
               st_nxt.mSync = 1'b0;
               if (!st_r.write) st_nxt.data = hb.dataS;
               if (hb.parErr) begin
                  st_nxt.status[`ST_ERR_PAR] = 1'b1;
                  st_nxt.status[`ST_ERR] = 1'b1;
                  st_nxt.count = 16'h0;
               end else begin
                  st_nxt.addr = st_r.addr + 18'h2;
                  st_nxt.count = (st_r.count > 16'h2) ? st_r.count - 16'h2 : 16'h0;
               end
               st_nxt.wcnt = st_r.wcnt - 8'h1;
               st_nxt.ds = DS_REL;
            end else if (st_r.tmr >= 32'(TMO_CYC)) begin
               st_nxt.mSync = 1'b0;
               st_nxt.status[`ST_ERR_TMO] = 1'b1;
               st_nxt.status[`ST_ERR] = 1'b1;
               st_nxt.count = 16'h0;
               st_nxt.ds = DS_REL;
            end
         end
         DS_REL: begin
            if (!hb.sSync) begin
               if (st_r.count != 16'h0 && st_r.wcnt != 8'h0) begin
                  st_nxt.ds = DS_XFER;
               end else begin
                  st_nxt.busBusy = 1'b0;
                  st_nxt.tmr = st_r.gap;
                  if (st_r.count == 16'h0) begin
                     st_nxt.status[`ST_DONE] = 1'b1;
                     st_nxt.ds = DS_IDLE;
                  end else begin
                     st_nxt.ds = DS_GAP;
                  end
               end
            end
         end
         DS_GAP: begin
            if (st_r.tmr == 32'h0) begin
               st_nxt.npReq = 1'b1;
               st_nxt.ds = DS_REQ;
            end else begin
               st_nxt.tmr = st_r.tmr - 32'h1;
            end
         end
         default: st_nxt.ds = DS_IDLE;
      endcase
      // Interrupt request when enabled and pending
      pend = st_r.ie && (st_r.status[`ST_DONE] || st_r.status[`ST_ERR]);
      case (st_r.is)
         IS_IDLE: begin
            st_nxt.busReq = 5'h0;
            if (pend && st_r.lvl >= 3'd4) begin
               st_nxt.busReq = 5'(5'h1 << (st_r.lvl - 3'd3));
               st_nxt.is = IS_REQ;
            end
         end
         IS_REQ: begin
            st_nxt.busReq = (st_r.lvl >= 3'd4) ? 5'(5'h1 << (st_r.lvl - 3'd3)) : 5'h0;
            if (!pend) begin
               st_nxt.busReq = 5'h0;
               st_nxt.is = IS_IDLE;
            end else if (hb.intrAck) begin
               st_nxt.busReq = 5'h0;
               st_nxt.vecOut = st_r.vector;
               st_nxt.is = IS_VEC;
            end
         end
         IS_VEC: begin
            if (!hb.intrAck) begin
               st_nxt.vecOut = 16'h0;
               st_nxt.ie = 1'b0;
               st_nxt.is = IS_IDLE;
            end
         end
         default: st_nxt.is = IS_IDLE;
      endcase
      st_nxt.irq = |(st_r.status & st_r.mask & 7'h63);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.awr <= 1'b1;
         st_r.wr <= 1'b1;
         st_r.arready <= 1'b1;
         st_r.gap <= 32'(GAP_CYC);
         st_r.burst <= 8'(`WORDS_PER_ACQ);
         st_r.lvl <= LEVEL;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.awr;
   assign s_axi_wready = st_r.wr;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign irq = st_r.irq;
   assign hb.busReq = st_r.busReq;
   assign hb.npReq = st_r.npReq;
   assign hb.selAck = st_r.selAck;
   assign hb.busBusy = st_r.busBusy;
   assign hb.addr = st_r.addr;
   assign hb.dataM = st_r.dataM;
   assign hb.vector = st_r.vecOut;
   assign hb.dirOut = st_r.dirOut;
   assign hb.mSync = st_r.mSync;
endmodule
`default_nettype wire

// file: shared/hbm_consts.svh
`ifndef HBM_CONSTS_SVH
`define HBM_CONSTS_SVH

`define CLK_PERIOD_NS      5
`define IDLE_GAP_NS        4000
`define IDLE_GAP_CYC       (`IDLE_GAP_NS / `CLK_PERIOD_NS)
`define WORDS_PER_ACQ      4
`define IRQ_LEVEL_DEFAULT  5
`define SYNC_TIMEOUT_CYC   2000

`define REG_CTRL           8'h00
`define REG_GAP            8'h04
`define REG_BURST          8'h08
`define REG_ADDR           8'h0c
`define REG_COUNT          8'h10
`define REG_BLOCK          8'h14
`define REG_VECTOR         8'h18
`define REG_STATUS         8'h1c
`define REG_MASK           8'h20
`define REG_DATA           8'h24

`define CTRL_START         0
`define CTRL_WRITE         1
`define CTRL_IE            2
`define CTRL_LVL_LO        4

`define ST_DONE            0
`define ST_ERR             1
`define ST_BUSY            4
`define ST_ERR_TMO         5
`define ST_ERR_PAR         6

`define BUS_OKAY           2'b00
`define BUS_SLVERR         2'b10

`endif

// file: shared/hbm_pkg.sv
package hbm_pkg;
   typedef enum logic [2:0] {
      DS_IDLE = 3'b000,
      DS_REQ  = 3'b001,
      DS_XFER = 3'b010,
      DS_WAIT = 3'b011,
      DS_REL  = 3'b100,
      DS_GAP  = 3'b101
   } dma_state_t;

   typedef enum logic [1:0] {
      IS_IDLE = 2'b00,
      IS_REQ  = 2'b01,
      IS_VEC  = 2'b10
   } irq_state_t;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_ANS  = 2'b01,
      HS_DROP = 2'b10
   } host_state_t;
endpackage

// file: shared/host_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface host_bus_if;
   logic [4:0]  busReq;
   logic [4:0]  busGrant;
   logic        npReq;
   logic        npGrant;
   logic        selAck;
   logic        busBusy;
   logic        intrAck;
   logic [17:0] addr;
   logic [15:0] dataM;
   logic [15:0] dataS;
   logic [15:0] vector;
   logic        dirOut;
   logic        mSync;
   logic        sSync;
   logic        parErr;

   modport ctrl (output busReq, npReq, selAck, busBusy, addr, dataM, vector, dirOut, mSync,
                 input busGrant, npGrant, intrAck, dataS, sSync, parErr);
   modport proc (input busReq, npReq, selAck, busBusy, addr, dataM, vector, dirOut, mSync,
                 output busGrant, npGrant, intrAck, dataS, sSync, parErr);
endinterface
`default_nettype wire

// file: hdl/host_bus_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbm_consts.svh"
module host_bus_arbiter
   import hbm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [2:0]  cpuLevel,
   input  wire logic        parInject,
   input  wire logic [15:0] memData,
   output logic [15:0]      vecSeen,
   output logic             vecStrobe,
   output logic [17:0]      lastAddr,
   output logic [15:0]      lastData,
   host_bus_if.proc         hb
);
   typedef struct packed {
      logic        npGrant;
      logic        intrAck;
      logic [4:0]  busGrant;
      logic        sSync;
      logic [15:0] dataS;
      logic        parErr;
      logic [15:0] vecSeen;
      logic        vecStrobe;
      logic [17:0] lastAddr;
      logic [15:0] lastData;
      host_state_t hs;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   always_comb begin
      logic [2:0] top;
      top = 3'd0;
      st_nxt = st_r;
      st_nxt.vecStrobe = 1'b0;
      for (int i = 0; i < 5; i++) begin
         if (hb.busReq[i]) top = 3'(i + 3);
      end
      if (hb.npReq && !hb.selAck) st_nxt.npGrant = 1'b1;
      else st_nxt.npGrant = 1'b0;
      // Single chain position: nearest device gets grant
      if (hb.busReq != 5'h0 && top > cpuLevel) begin
         st_nxt.intrAck = 1'b1;
         st_nxt.busGrant = 5'(5'h1 << (top - 3'd3));
      end else if (hb.busReq == 5'h0 && st_r.intrAck && hb.vector != 16'h0) begin
         st_nxt.vecSeen = hb.vector;
         st_nxt.vecStrobe = 1'b1;
         st_nxt.intrAck = 1'b0;
         st_nxt.busGrant = 5'h0;
      end
      case (st_r.hs)
         HS_IDLE: begin
            if (hb.mSync) begin
               st_nxt.sSync = 1'b1;
               st_nxt.parErr = parInject;
               st_nxt.lastAddr = hb.addr;
               if (hb.dirOut) st_nxt.lastData = hb.dataM;
               else st_nxt.dataS = memData;
               st_nxt.hs = HS_ANS;
            end
         end
         HS_ANS: begin
            if (!hb.mSync) begin
               st_nxt.sSync = 1'b0;
               st_nxt.parErr = 1'b0;
               st_nxt.hs = HS_IDLE;
            end
         end
         default: st_nxt.hs = HS_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) st_r <= '0;
      else st_r <= st_nxt;
   end

   assign hb.npGrant = st_r.npGrant;
   assign hb.intrAck = st_r.intrAck;
   assign hb.busGrant = st_r.busGrant;
   assign hb.sSync = st_r.sSync;
   assign hb.dataS = st_r.dataS;
   assign hb.parErr = st_r.parErr;
   assign vecSeen = st_r.vecSeen;
   assign vecStrobe = st_r.vecStrobe;
   assign lastAddr = st_r.lastAddr;
   assign lastData = st_r.lastData;
endmodule
`default_nettype wire

// file: tb/host_bus_dma_interrupt_master_sva.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_dma_interrupt_master_sva
   import hbm_pkg::*;
#(
   parameter int MAX_BURST = 4
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [4:0]  busReq,
   input wire logic        npReq,
   input wire logic        npGrant,
   input wire logic        busBusy,
   input wire logic        intrAck,
   input wire logic [17:0] addr,
   input wire logic [15:0] vector,
   input wire logic        mSync,
   input wire logic        sSync
);
   logic [3:0]  wordCnt_r;
   logic [17:0] prevAddr_r;
   logic        mSyncD_r;
   logic        seen_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Words and addresses of one acquisition
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wordCnt_r  <= 4'h0;
         prevAddr_r <= 18'h0;
         mSyncD_r   <= 1'b0;
         seen_r     <= 1'b0;
      end else begin
         mSyncD_r <= mSync;
         if (!busBusy) begin
            wordCnt_r <= 4'h0;
            seen_r    <= 1'b0;
         end else if (mSync && !mSyncD_r) begin
            wordCnt_r  <= wordCnt_r + 4'h1;
            prevAddr_r <= addr;
            seen_r     <= 1'b1;
         end
      end
   end
   sequence vecOut_s;
      ##[1:4] vector != 16'h0;
   endsequence
   sequence quietReq_s;
      !npReq [*8];
   endsequence
   req_onehot_a: assert property ($onehot0(busReq))
      else $error("several interrupt levels requested");
   ack_after_req_a: assert property ($rose(intrAck) |-> $past(busReq) != 5'h0)
      else $error("acknowledge without request");
   vec_on_ack_a: assert property ($rose(intrAck) |-> vecOut_s)
      else $error("no vector after acknowledge");
   vec_idle_a: assert property (!intrAck && !$past(intrAck) |-> vector == 16'h0)
      else $error("vector driven without acknowledge");
   grant_first_a: assert property ($rose(busBusy) |-> $past(npGrant))
      else $error("mastership taken without grant");
   burst_len_a: assert property ($fell(busBusy) |-> wordCnt_r inside {[1:MAX_BURST]})
      else $error("acquisition word count out of range");
   idle_gap_a: assert property ($fell(busBusy) |-> quietReq_s)
      else $error("request too soon after release");
   sync_in_busy_a: assert property (mSync |-> busBusy)
      else $error("master sync without mastership");
   sync_drop_a: assert property ($fell(mSync) |-> $past(sSync))
      else $error("master sync dropped before slave sync");
   sync_clear_a: assert property ($rose(mSync) |-> !sSync)
      else $error("master sync raised over slave sync");
   addr_step_a: assert property (seen_r && $rose(mSync) |-> addr == prevAddr_r + 18'h2)
      else $error("address did not advance by one word");
endmodule
`default_nettype wire

// file: tb/host_bus_dma_interrupt_master_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "hbm_consts.svh"
module host_bus_dma_interrupt_master_bench
   import hbm_pkg::*;
;
   localparam int GAP = 10;
   typedef struct packed {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} note_t;
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [2:0]  levelLink = 3'h5, cpuLevel = 3'h7;
   logic        parInject = 1'b0, npReqD = 1'b0;
   logic [15:0] memData = 16'h0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq, vecStrobe;
   logic [1:0]  bresp, rresp;
   logic [15:0] vecSeen, lastData, vec;
   logic [17:0] lastAddr, base;
   logic [31:0] lfsr = 32'h509180e0, dat;
   note_t       notes[$], n;
   logic [15:0] vecNotes[$];
   int          mismatches = 0, checked = 0, cycles = 0, acq = 0, gapCnt = 1000, gapMin = 1000;
   host_bus_if hb ();
   disc_bus_master #(.GAP_CYC(GAP), .TMO_CYC(50)) disc_bus_master_i (.clk(clk), .rst_n(rst_n),
      .levelLink(levelLink), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .hb(hb));
   host_bus_arbiter host_bus_arbiter_i (.clk(clk), .rst_n(rst_n), .cpuLevel(cpuLevel), .parInject(parInject),
      .memData(memData), .vecSeen(vecSeen), .vecStrobe(vecStrobe), .lastAddr(lastAddr), .lastData(lastData),
      .hb(hb));
   host_bus_dma_interrupt_master_sva #(.MAX_BURST(4)) host_bus_dma_interrupt_master_sva_i (.clk(clk),
      .rst_n(rst_n), .busReq(hb.busReq), .npReq(hb.npReq), .npGrant(hb.npGrant), .busBusy(hb.busBusy),
      .intrAck(hb.intrAck), .addr(hb.addr), .vector(hb.vector), .mSync(hb.mSync), .sSync(hb.sSync));
   always #2.5 clk = ~clk;
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      fork
         begin do @(posedge clk); while (!awready); awvalid <= 1'b0; end
         begin do @(posedge clk); while (!wready); wvalid <= 1'b0; end
      join
      while (!bvalid) @(posedge clk);
      cmp("bresp", (a <= `REG_DATA && a[1:0] == 2'b00) ? {30'h0, `BUS_OKAY} : {30'h0, `BUS_SLVERR}, {30'h0, bresp});
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      notes.push_back('{d, m, r});
      @(posedge clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
   endtask
   task automatic dma(input logic [31:0] ctl, input logic [31:0] bytes);
      lfsr = nextRand(lfsr);
      base = {lfsr[17:1], 1'b0};
      wr(`REG_ADDR, {14'h0, base});
      wr(`REG_COUNT, bytes);
      gapCnt = 1000;
      wr(`REG_CTRL, ctl);
      while (!irq) @(posedge clk);
   endtask
   // Result watcher and acquisition counters
   always @(posedge clk) begin
      if (hb.selAck) acq++;
      if (hb.busBusy) gapCnt = 0; else gapCnt++;
      if (hb.npReq && !npReqD && gapCnt < gapMin) gapMin = gapCnt;
      npReqD = hb.npReq;
      if (rvalid && rready && notes.size() > 0) begin
         n = notes.pop_front();
         cmp("rdata", n.data & n.mask, rdata & n.mask);
         cmp("rresp", {30'h0, n.resp}, {30'h0, rresp});
      end
      if (vecStrobe && vecNotes.size() > 0) cmp("vecSeen", {16'h0, vecNotes.pop_front()}, {16'h0, vecSeen});
   end
   // Timeout guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(`REG_GAP, GAP, 32'hffffffff, `BUS_OKAY);
      rd(`REG_BURST, `WORDS_PER_ACQ, 32'hffffffff, `BUS_OKAY);
      rd(`REG_CTRL, 32'h50, 32'h70, `BUS_OKAY);
      rd(8'h40, 32'h0, 32'h0, `BUS_SLVERR);
      wr(8'h40, 32'h0);
      lfsr = nextRand(lfsr);
      wr(`REG_BLOCK, lfsr);
      rd(`REG_BLOCK, lfsr, 32'hffffffff, `BUS_OKAY);
      wr(`REG_MASK, 32'h3);
      for (int k = 0; k < 2; k++) begin
         if (k == 1) wr(`REG_BURST, 32'h2);
         if (k == 1) wr(`REG_GAP, 32'd20);
         lfsr = nextRand(lfsr);
         dat = lfsr;
         wr(`REG_DATA, dat);
         acq = 0;
         gapMin = 1000;
         dma(32'h3, 32'd12);
         repeat (2) @(posedge clk);
         cmp("busReq", 32'h0, {27'h0, hb.busReq});
         cmp("acquisitions", k ? 32'd3 : 32'd2, 32'(acq));
         cmp("gapOk", 32'h1, {31'h0, gapMin >= (k ? 20 : GAP)});
         cmp("lastAddr", {14'h0, 18'(base + 18'd10)}, {14'h0, lastAddr});
         cmp("lastData", {16'h0, dat[15:0]}, {16'h0, lastData});
         rd(`REG_STATUS, 32'h1, 32'h73, `BUS_OKAY);
         rd(`REG_STATUS, 32'h0, 32'h73, `BUS_OKAY);
         cmp("irq", 32'h0, {31'h0, irq});
      end
      lfsr = nextRand(lfsr);
      memData <= lfsr[15:0];
      dma(32'h1, 32'd2);
      rd(`REG_DATA, {16'h0, memData}, 32'hffff, `BUS_OKAY);
      rd(`REG_STATUS, 32'h1, 32'h73, `BUS_OKAY);
      parInject <= 1'b1;
      dma(32'h1, 32'd8);
      parInject <= 1'b0;
      rd(`REG_STATUS, 32'h42, 32'h62, `BUS_OKAY);
      cmp("busBusy", 32'h0, {31'h0, hb.busBusy});
      lfsr = nextRand(lfsr);
      vec = {lfsr[15:3], 3'b100};
      wr(`REG_VECTOR, {16'h0, vec});
      dma(32'h7, 32'd2);
      for (int l = 4; l < 7; l++) begin
         levelLink <= 3'(l);
         repeat (3) @(posedge clk);
         cmp("ackReq", 32'h1 << (l - 3), {26'h0, hb.intrAck, hb.busReq});
      end
      vecNotes.push_back(vec);
      cpuLevel <= 3'h0;
      while (!hb.intrAck) @(posedge clk);
      cmp("busGrant", 32'h8, {27'h0, hb.busGrant});
      while (!vecStrobe) @(posedge clk);
      repeat (4) @(posedge clk);
      cmp("busReq", 32'h0, {27'h0, hb.busReq});
      rd(`REG_STATUS, 32'h1, 32'h73, `BUS_OKAY);
      tally_and_finish();
   end
endmodule
`default_nettype wire
